// >>> design/mfg_clk_loss_det.sv
`timescale 1ns/1ns
`default_nettype none
module mfg_clk_loss_det
   import mfg_pkg::*;
#(
   parameter int LIMIT = 100
) (
   input wire logic aclk,    // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   mfg_loss_if.det  lif      // Tick, reference level and loss flag.
);
   localparam int CW = $clog2(LIMIT + 1);

   initial begin
      if (LIMIT < 2) begin
         $error("mfg_clk_loss_det: LIMIT must be at least 2");
      end
   end

   logic          ref_q;
   logic [CW-1:0] cnt_q;
   logic          lost_q;
   wire           edge_seen = lif.ref_level ^ ref_q;
   wire           at_limit  = (cnt_q == CW'(LIMIT));

   // ----
   // Oscillator ticks between reference edges
   // ----
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_q  <= 1'b0;
         cnt_q  <= '0;
         lost_q <= 1'b0;
      end else begin
         ref_q <= lif.ref_level;
         if (edge_seen) begin
            cnt_q  <= '0;
            lost_q <= 1'b0;
         end else if (lif.tick && !at_limit) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (at_limit) begin
            lost_q <= 1'b1;
         end
      end
   end

   assign lif.lost = lost_q;
endmodule
`default_nettype wire

// >>> design/mfg_fault_gate.sv
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - In the motor drive state all three low-side gates go off while the reference clock is lost.
// - The clock-loss shutdown lifts by itself as soon as the reference clock toggles again.
// - The reference clock counts as lost when it holds one level for longer than about 1/34 of the lock time.
// - In the motor drive state an over-temperature trip turns all three low-side gates off.
// - The thermal trip clears only once the temperature falls below trip minus hysteresis.
// - While undervoltage is active every gate, high and low side, is off in any mode.
// - Undervoltage lockout ends only when the supply rises to trip plus hysteresis.
// - The speed pulse goes high below the reference and low only above reference plus hysteresis.
// - The speed-pulse comparator keeps running in stop mode.
// - Start/stop low selects start mode; high selects stop mode with every gate off.
// - Brake input high engages the brake; drive state is start mode with brake released.
// - Lock protection is inhibited while clock-loss, thermal or undervoltage protection acts.
module mfg_fault_gate
   import mfg_pkg::*;
#(
   parameter int CLK_LOSS_CYCLES = CLK_LOSS_CYC,
   parameter int OSC_DIV         = OSC_DIV_DEF
) (
   input  wire logic        aclk,               // System clock, 125 MHz.
   input  wire logic        aresetn,            // Synchronous reset, active low.
   input  wire logic [7:0]  s_axi_awaddr,       // Write address.
   input  wire logic        s_axi_awvalid,      // Write address valid.
   output logic             s_axi_awready,      // Write address ready.
   input  wire logic [31:0] s_axi_wdata,        // Write data.
   input  wire logic [3:0]  s_axi_wstrb,        // Write byte strobes.
   input  wire logic        s_axi_wvalid,       // Write data valid.
   output logic             s_axi_wready,       // Write data ready.
   output logic [1:0]       s_axi_bresp,        // Write response.
   output logic             s_axi_bvalid,       // Write response valid.
   input  wire logic        s_axi_bready,       // Write response ready.
   input  wire logic [7:0]  s_axi_araddr,       // Read address.
   input  wire logic        s_axi_arvalid,      // Read address valid.
   output logic             s_axi_arready,      // Read address ready.
   output logic [31:0]      s_axi_rdata,        // Read data.
   output logic [1:0]       s_axi_rresp,        // Read response.
   output logic             s_axi_rvalid,       // Read data valid.
   input  wire logic        s_axi_rready,       // Read data ready.
   input  wire logic        ref_clk_in,         // Speed reference clock level.
   input  wire logic        start_stop_n,       // Low selects start mode.
   input  wire logic        brake_input,        // High engages the brake.
   input  wire logic [7:0]  temp_code,          // Junction temperature code.
   input  wire logic [7:0]  supply_code,        // Supply voltage code.
   input  wire logic [7:0]  fb_amp_code,        // Feedback amplifier output code.
   input  wire logic [2:0]  gate_demand_high,   // Commutation demand, high side.
   input  wire logic [2:0]  gate_demand_low,    // Commutation demand, low side.
   output logic             phase_u_high_gate,  // Phase U high-side gate.
   output logic             phase_v_high_gate,  // Phase V high-side gate.
   output logic             phase_w_high_gate,  // Phase W high-side gate.
   output logic             phase_u_low_gate,   // Phase U low-side gate.
   output logic             phase_v_low_gate,   // Phase V low-side gate.
   output logic             phase_w_low_gate,   // Phase W low-side gate.
   output logic             speed_pulse_output, // Speed pulse comparator output.
   output logic             lock_inhibit,       // High suppresses lock protection.
   output logic             irq                 // Interrupt, active high level.
);
   localparam int LOSS_LIMIT = CLK_LOSS_CYCLES / OSC_DIV;
   localparam int DW         = $clog2(OSC_DIV);

   initial begin
      if (OSC_DIV < 2 || LOSS_LIMIT < 2) begin
         $error("mfg_fault_gate: OSC_DIV and CLK_LOSS_CYCLES/OSC_DIV must be at least 2");
      end
   end

   // ----
   // Protection oscillator and clock-loss detector
   // ----
   logic [DW-1:0] osc_cnt_q;
   logic          osc_tick_q;
   wire           osc_wrap = (osc_cnt_q == DW'(OSC_DIV - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_cnt_q  <= '0;
         osc_tick_q <= 1'b0;
      end else begin
         osc_cnt_q  <= osc_wrap ? '0 : osc_cnt_q + 1'b1;
         osc_tick_q <= osc_wrap;
      end
   end

   mfg_loss_if lif ();
   assign lif.tick      = osc_tick_q;
   assign lif.ref_level = ref_clk_in;

   mfg_clk_loss_det #(
      .LIMIT (LOSS_LIMIT)
   ) u_det (
      .aclk    (aclk),
      .aresetn (aresetn),
      .lif     (lif.det)
   );

   // ----
   // Configuration registers
   // ----
   logic [7:0]      temp_trip_q, temp_hyst_q;
   logic [7:0]      uv_trip_q, uv_hyst_q;
   logic [7:0]      fb_ref_q, fb_hyst_q;
   logic [EV_W-1:0] irq_stat_q, irq_mask_q;

   // ----
   // Hysteresis comparators
   // ----
   logic tsd_q, uv_q, fgs_q;
   wire [8:0] temp_rel = {1'b0, temp_trip_q} - {1'b0, temp_hyst_q};
   wire [8:0] uv_rel   = {1'b0, uv_trip_q} + {1'b0, uv_hyst_q};
   wire [8:0] fb_hi    = {1'b0, fb_ref_q} + {1'b0, fb_hyst_q};
   wire       tsd_set  = temp_code >= temp_trip_q;
   wire       tsd_clr  = temp_rel[8] ? 1'b0 : ({1'b0, temp_code} < temp_rel);
   wire       uv_set   = supply_code < uv_trip_q;
   wire       uv_clr   = {1'b0, supply_code} >= uv_rel;
   wire       fgs_set  = fb_amp_code < fb_ref_q;
   wire       fgs_clr  = {1'b0, fb_amp_code} > fb_hi;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tsd_q <= 1'b0;
         uv_q  <= 1'b1;
         fgs_q <= 1'b0;
      end else begin
         if (tsd_set) begin
            tsd_q <= 1'b1;
         end else if (tsd_clr) begin
            tsd_q <= 1'b0;
         end
         if (uv_set) begin
            uv_q <= 1'b1;
         end else if (uv_clr) begin
            uv_q <= 1'b0;
         end
         if (fgs_set) begin
            fgs_q <= 1'b1;
         end else if (fgs_clr) begin
            fgs_q <= 1'b0;
         end
      end
   end

   // ----
   // Mode decode and gate control
   // ----
   wire       start_mode = ~start_stop_n;
   wire       brake_on   = brake_input;
   wire       drive      = start_mode & ~brake_on;
   wire       low_kill   = drive & (lif.lost | tsd_q);
   wire       all_off    = uv_q | ~start_mode;
   wire [2:0] hi_d       = (all_off | brake_on) ? 3'h0 : gate_demand_high;
   wire [2:0] lo_d       = all_off  ? 3'h0 :
                           brake_on ? 3'h7 :
                           low_kill ? 3'h0 : gate_demand_low;
   // Thermal and undervoltage count in every state so that lock protection stays
   // quiet even while the host is still braking.
   wire       inhib_d    = lif.lost | tsd_q | uv_q;

   logic [2:0] hi_q, lo_q;
   logic       inhib_q, fgs_out_q, irq_q;

   // ----
   // Interrupt events
   // ----
   logic            lost_d1_q, tsd_d1_q, uv_d1_q, fgs_d1_q;
   wire [EV_W-1:0]  ev = {fgs_q & ~fgs_d1_q, uv_q & ~uv_d1_q,
                          tsd_q & ~tsd_d1_q, lif.lost & ~lost_d1_q};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hi_q      <= 3'h0;
         lo_q      <= 3'h0;
         inhib_q   <= 1'b0;
         fgs_out_q <= 1'b0;
         irq_q     <= 1'b0;
         lost_d1_q <= 1'b0;
         tsd_d1_q  <= 1'b0;
         uv_d1_q   <= 1'b1;
         fgs_d1_q  <= 1'b0;
      end else begin
         hi_q      <= hi_d;
         lo_q      <= lo_d;
         inhib_q   <= inhib_d;
         fgs_out_q <= fgs_q;
         irq_q     <= |(irq_stat_q & irq_mask_q);
         lost_d1_q <= lif.lost;
         tsd_d1_q  <= tsd_q;
         uv_d1_q   <= uv_q;
         fgs_d1_q  <= fgs_q;
      end
   end

   assign phase_u_high_gate  = hi_q[0];
   assign phase_v_high_gate  = hi_q[1];
   assign phase_w_high_gate  = hi_q[2];
   assign phase_u_low_gate   = lo_q[0];
   assign phase_v_low_gate   = lo_q[1];
   assign phase_w_low_gate   = lo_q[2];
   assign speed_pulse_output = fgs_out_q;
   assign lock_inhibit       = inhib_q;
   assign irq                = irq_q;

   // ----
   // AXI4-Lite write channel
   // ----
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        awready_q, wready_q, bvalid_q;
   logic [1:0]  bresp_q;

   wire        aw_hs    = s_axi_awvalid & awready_q;
   wire        w_hs     = s_axi_wvalid & wready_q;
   wire        commit   = ~awready_q & ~wready_q & ~bvalid_q;
   wire [31:0] bmask    = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                           {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire [31:0] wmasked  = w_data_q & bmask;
   wire        wr_irq   = commit & (aw_addr_q == ADDR_IRQ);
   wire        wr_mask  = commit & (aw_addr_q == ADDR_MASK);
   wire        wr_temp  = commit & (aw_addr_q == ADDR_TEMP);
   wire        wr_supp  = commit & (aw_addr_q == ADDR_SUPP);
   wire        wr_fb    = commit & (aw_addr_q == ADDR_FB);
   wire        wr_hit   = wr_irq | wr_mask | wr_temp | wr_supp | wr_fb |
                          (aw_addr_q == ADDR_STATE);
   wire [15:0] m16      = bmask[15:0];
   wire [EV_W-1:0] clr  = wr_irq ? wmasked[EV_W-1:0] : '0;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [15:0] m);
      merge16 = (old & ~m) | (nw & m);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end else begin
         if (aw_hs) begin
            awready_q <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            wready_q <= 1'b0;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (commit) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q  <= '0;
         irq_mask_q  <= MASK_RST;
         temp_trip_q <= TEMP_TRIP_RST;
         temp_hyst_q <= TEMP_HYST_RST;
         uv_trip_q   <= UV_TRIP_RST;
         uv_hyst_q   <= UV_HYST_RST;
         fb_ref_q    <= FB_REF_RST;
         fb_hyst_q   <= FG_HYST_CODE;
      end else begin
         // A new event in the clearing cycle stays set.
         irq_stat_q <= (irq_stat_q & ~clr) | ev;
         if (wr_mask) begin
            irq_mask_q <= (irq_mask_q & ~m16[EV_W-1:0]) | wmasked[EV_W-1:0];
         end
         if (wr_temp) begin
            {temp_hyst_q, temp_trip_q} <= merge16({temp_hyst_q, temp_trip_q}, w_data_q[15:0], m16);
         end
         if (wr_supp) begin
            {uv_hyst_q, uv_trip_q} <= merge16({uv_hyst_q, uv_trip_q}, w_data_q[15:0], m16);
         end
         if (wr_fb) begin
            {fb_hyst_q, fb_ref_q} <= merge16({fb_hyst_q, fb_ref_q}, w_data_q[15:0], m16);
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   // ----
   // AXI4-Lite read channel
   // ----
   logic        arready_q, rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   wire        ar_hs   = s_axi_arvalid & arready_q;
   wire [31:0] state_w = {24'h000000, inhib_q, drive, brake_on, start_mode,
                          fgs_q, uv_q, tsd_q, lif.lost};
   wire        rd_ok   = (s_axi_araddr == ADDR_STATE) | (s_axi_araddr == ADDR_IRQ) |
                         (s_axi_araddr == ADDR_MASK)  | (s_axi_araddr == ADDR_TEMP) |
                         (s_axi_araddr == ADDR_SUPP)  | (s_axi_araddr == ADDR_FB);
   wire [31:0] rd_mux  =
      (s_axi_araddr == ADDR_STATE) ? state_w :
      (s_axi_araddr == ADDR_IRQ)   ? {28'h0000000, irq_stat_q} :
      (s_axi_araddr == ADDR_MASK)  ? {28'h0000000, irq_mask_q} :
      (s_axi_araddr == ADDR_TEMP)  ? {16'h0000, temp_hyst_q, temp_trip_q} :
      (s_axi_araddr == ADDR_SUPP)  ? {16'h0000, uv_hyst_q, uv_trip_q} :
      (s_axi_araddr == ADDR_FB)    ? {16'h0000, fb_hyst_q, fb_ref_q} : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
      end else if (ar_hs) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_mux;
         rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
endmodule
`default_nettype wire

// >>> design/mfg_loss_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mfg_loss_if;
   logic tick;
   logic ref_level;
   logic lost;
   modport det (input tick, input ref_level, output lost);
   modport ctl (output tick, output ref_level, input lost);
endinterface
`default_nettype wire

// >>> design/mfg_pkg.sv
package mfg_pkg;
   // ----
   // Timing
   // ----
   localparam int    CLK_PERIOD_NS   = 8;
   localparam int    SET_TIME_MS     = 2900;
   localparam int    SET_TO_LOSS_DIV = 34;
   localparam longint CLK_LOSS_NS    = longint'(SET_TIME_MS) * 64'd1000000 / SET_TO_LOSS_DIV;
   localparam int    CLK_LOSS_CYC    = int'(CLK_LOSS_NS / CLK_PERIOD_NS);
   localparam int    OSC_DIV_DEF     = 256;
   localparam int    FG_HYST_MV      = 200;
   localparam int    CODE_LSB_MV     = 10;
   localparam logic [7:0] FG_HYST_CODE = 8'(FG_HYST_MV / CODE_LSB_MV);

   // ----
   // Register map
   // ----
   localparam logic [7:0] ADDR_STATE = 8'h00;
   localparam logic [7:0] ADDR_IRQ   = 8'h04;
   localparam logic [7:0] ADDR_MASK  = 8'h08;
   localparam logic [7:0] ADDR_TEMP  = 8'h0C;
   localparam logic [7:0] ADDR_SUPP  = 8'h10;
   localparam logic [7:0] ADDR_FB    = 8'h14;

   localparam int EV_CLK  = 0;
   localparam int EV_TSD  = 1;
   localparam int EV_UV   = 2;
   localparam int EV_FGS  = 3;
   localparam int EV_W    = 4;
   localparam int ST_START = 4;
   localparam int ST_BRAKE = 5;
   localparam int ST_DRIVE = 6;
   localparam int ST_INHIB = 7;

   localparam logic [7:0] TEMP_TRIP_RST = 8'hC8;
   localparam logic [7:0] TEMP_HYST_RST = 8'h14;
   localparam logic [7:0] UV_TRIP_RST   = 8'h50;
   localparam logic [7:0] UV_HYST_RST   = 8'h0A;
   localparam logic [7:0] FB_REF_RST    = 8'h80;
   localparam logic [EV_W-1:0] MASK_RST = 4'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> testbench/mfg_fault_gate_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module mfg_fault_gate_monitor
   import mfg_pkg::*;
#(
   parameter int CLK_LOSS_CYCLES = 64
) (
   input wire logic       aclk,               // Clock.
   input wire logic       aresetn,            // Reset, active low.
   input wire logic       ref_clk_in,         // Reference clock.
   input wire logic       start_stop_n,       // Stop when high.
   input wire logic       brake_input,        // Brake when high.
   input wire logic [7:0] temp_code,          // Temperature.
   input wire logic [7:0] supply_code,        // Supply.
   input wire logic [7:0] fb_amp_code,        // Feedback level.
   input wire logic [2:0] gate_demand_high,   // High demand.
   input wire logic [2:0] gate_demand_low,    // Low demand.
   input wire logic       phase_u_high_gate,  // Gate.
   input wire logic       phase_v_high_gate,  // Gate.
   input wire logic       phase_w_high_gate,  // Gate.
   input wire logic       phase_u_low_gate,   // Gate.
   input wire logic       phase_v_low_gate,   // Gate.
   input wire logic       phase_w_low_gate,   // Gate.
   input wire logic       speed_pulse_output, // Speed pulse.
   input wire logic       lock_inhibit        // Lock inhibit.
);
   // ----
   // Checks
   // ----
   logic [2:0] hi;
   logic [2:0] lo;
   logic       ref_q;
   int         quiet_q;
   assign hi = {phase_w_high_gate, phase_v_high_gate, phase_u_high_gate};
   assign lo = {phase_w_low_gate, phase_v_low_gate, phase_u_low_gate};
   // Saturating count of cycles since the last reference edge.
   always_ff @(posedge aclk) begin
      ref_q <= ref_clk_in;
      if (!aresetn || ref_clk_in != ref_q) quiet_q <= 0;
      else if (quiet_q < CLK_LOSS_CYCLES + 8) quiet_q <= quiet_q + 1;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_stop_off; $past(start_stop_n) |-> hi == 3'h0 && lo == 3'h0; endproperty
   a_stop_off: assert property (p_stop_off) else $error("gate on in stop mode");
   property p_brake; $past(aresetn) && $past(!start_stop_n && brake_input) && !lock_inhibit
      |-> hi == 3'h0 && lo == 3'h7; endproperty
   a_brake: assert property (p_brake) else $error("short brake pattern wrong");
   property p_drive_off; $past(!start_stop_n && !brake_input) && lock_inhibit |-> lo == 3'h0;
   endproperty
   a_drive_off: assert property (p_drive_off) else $error("low side on under fault");
   property p_drive_pass; $past(aresetn) && $past(!start_stop_n && !brake_input) && !lock_inhibit
      |-> hi == $past(gate_demand_high) && lo == $past(gate_demand_low); endproperty
   a_drive_pass: assert property (p_drive_pass) else $error("demand not passed");
   property p_uv; $past(aresetn) && $past(aresetn, 2) && $past(supply_code, 2) < UV_TRIP_RST
      |-> lock_inhibit && hi == 3'h0 && lo == 3'h0; endproperty
   a_uv: assert property (p_uv) else $error("gate on at low supply");
   property p_tsd; $past(aresetn) && $past(aresetn, 2) && $past(temp_code, 2) >= TEMP_TRIP_RST
      |-> lock_inhibit; endproperty
   a_tsd: assert property (p_tsd) else $error("no inhibit when hot");
   property p_fgs_hi; $past(aresetn) && $past(aresetn, 2) && $past(fb_amp_code, 2) < FB_REF_RST
      |-> speed_pulse_output; endproperty
   a_fgs_hi: assert property (p_fgs_hi) else $error("speed pulse not high");
   property p_fgs_stop; $past(aresetn) && $past(aresetn, 2) && $past(start_stop_n, 2)
      && $past(fb_amp_code, 2) > FB_REF_RST + FG_HYST_CODE |-> !speed_pulse_output; endproperty
   a_fgs_stop: assert property (p_fgs_stop) else $error("speed pulse stuck in stop");
   property p_loss; quiet_q == CLK_LOSS_CYCLES + 8 |-> lock_inhibit; endproperty
   a_loss: assert property (p_loss) else $error("reference loss not seen");
   property p_resume; $past(aresetn) && $changed(ref_clk_in) && $stable(supply_code)
      && $stable(temp_code) && supply_code >= UV_TRIP_RST + UV_HYST_RST
      && temp_code < TEMP_TRIP_RST - TEMP_HYST_RST |-> ##[1:3] !lock_inhibit; endproperty
   a_resume: assert property (p_resume) else $error("loss not lifted on edge");
endmodule
`default_nettype wire

// >>> testbench/mfg_fault_gate_test.sv
`timescale 1ns/1ns
`default_nettype none
module mfg_fault_gate_test;
   import mfg_pkg::*;
   localparam int LOSS = 64;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, ref_clk_in, start_stop_n, brake_input, host_run, irq;
   logic        phase_u_high_gate, phase_v_high_gate, phase_w_high_gate, phase_u_low_gate;
   logic        phase_v_low_gate, phase_w_low_gate, speed_pulse_output, lock_inhibit;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, temp_code, supply_code, fb_amp_code;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0]  gate_demand_high, gate_demand_low;
   logic [5:0]  gates;
   int          errors, comparisons;
   assign gates = {phase_w_high_gate, phase_v_high_gate, phase_u_high_gate,
                   phase_w_low_gate, phase_v_low_gate, phase_u_low_gate};
   mfg_host_model #(.HALF(8)) u_host (.aclk, .run(host_run), .ref_clk(ref_clk_in));
   mfg_fault_gate #(.CLK_LOSS_CYCLES(LOSS), .OSC_DIV(4)) DUT (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_clk_in, .start_stop_n,
      .brake_input, .temp_code, .supply_code, .fb_amp_code, .gate_demand_high, .gate_demand_low,
      .phase_u_high_gate, .phase_v_high_gate, .phase_w_high_gate, .phase_u_low_gate,
      .phase_v_low_gate, .phase_w_low_gate, .speed_pulse_output, .lock_inhibit, .irq);
   // ----
   // Tasks
   // ----
   task automatic stop_test();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic drv(input logic ss, input logic br, input logic [7:0] t, input logic [7:0] s,
                      input logic [7:0] f);
      @(posedge aclk);
      start_stop_n <= ss;
      brake_input <= br;
      temp_code <= t;
      supply_code <= s;
      fb_amp_code <= f;
      repeat (4) @(posedge aclk);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awready) aw = 1'b1;
         if (s_axi_wready) w = 1'b1;
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic t_power();
      drv(1'b0, 1'b0, 8'h40, 8'h59, 8'hA0);
      chk("gates_uv_hold", gates, 6'h00);
      drv(1'b0, 1'b0, 8'h40, 8'h5A, 8'hA0);
      chk("gates_uv_free", gates, 6'h2A);
      drv(1'b0, 1'b0, 8'h40, 8'h4F, 8'hA0);
      chk("gates_uv_trip", gates, 6'h00);
      drv(1'b0, 1'b0, 8'h40, 8'h5A, 8'hA0);
   endtask
   task automatic t_stop_brake();
      drv(1'b1, 1'b0, 8'h40, 8'h5A, 8'h7F);
      chk("gates_stop", gates, 6'h00);
      chk("pulse_stop", speed_pulse_output, 1'b1);
      drv(1'b1, 1'b0, 8'h40, 8'h5A, 8'h94);
      chk("pulse_band", speed_pulse_output, 1'b1);
      drv(1'b1, 1'b0, 8'h40, 8'h5A, 8'h95);
      chk("pulse_low", speed_pulse_output, 1'b0);
      drv(1'b0, 1'b1, 8'h40, 8'h5A, 8'h95);
      chk("gates_brake", gates, 6'h07);
   endtask
   task automatic t_loss_thermal();
      drv(1'b0, 1'b0, 8'h40, 8'h5A, 8'h95);
      chk("gates_drive", gates, 6'h2A);
      host_run <= 1'b0;
      repeat (40) @(posedge aclk);
      chk("gates_early", gates, 6'h2A);
      repeat (40) @(posedge aclk);
      chk("gates_lost", gates, 6'h28);
      chk("inhibit_lost", lock_inhibit, 1'b1);
      host_run <= 1'b1;
      repeat (16) @(posedge aclk);
      chk("gates_resume", gates, 6'h2A);
      drv(1'b0, 1'b0, 8'hC8, 8'h5A, 8'h95);
      chk("gates_hot", gates, 6'h28);
      drv(1'b0, 1'b0, 8'hB4, 8'h5A, 8'h95);
      chk("gates_band", gates, 6'h28);
      drv(1'b0, 1'b0, 8'hB3, 8'h5A, 8'h95);
      chk("gates_cool", gates, 6'h2A);
   endtask
   task automatic t_regs();
      axi_rd(ADDR_STATE, rd, rsp);
      chk("state", rd, 32'h50);
      axi_rd(ADDR_IRQ, rd, rsp);
      chk("irq_stat", rd, 32'h0F);
      chk("irq_masked", irq, 1'b0);
      axi_wr(ADDR_MASK, 32'h2, rsp);
      repeat (3) @(posedge aclk);
      chk("irq_on", irq, 1'b1);
      axi_wr(ADDR_IRQ, 32'h2, rsp);
      repeat (3) @(posedge aclk);
      chk("irq_off", irq, 1'b0);
      axi_rd(8'h40, rd, rsp);
      chk("rd_unmapped", {rd[29:0], rsp}, 32'h2);
      axi_wr(8'h40, 32'hF, rsp);
      chk("wr_unmapped", rsp, RESP_SLVERR);
   endtask
   // ----
   // Run
   // ----
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   initial begin
      repeat (5000) @(posedge aclk);
      errors++;
      stop_test();
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, start_stop_n, brake_input} = '0;
      {temp_code, supply_code, fb_amp_code, s_axi_wstrb} = {8'h40, 8'h00, 8'hA0, 4'hF};
      {gate_demand_high, gate_demand_low, host_run} = {3'h5, 3'h2, 1'b1};
      errors = 0;
      comparisons = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_power();
      t_stop_brake();
      t_loss_thermal();
      t_regs();
      stop_test();
   end
endmodule
bind mfg_fault_gate mfg_fault_gate_monitor #(.CLK_LOSS_CYCLES(CLK_LOSS_CYCLES)) u_mon (.aclk,
   .aresetn, .ref_clk_in, .start_stop_n, .brake_input, .temp_code, .supply_code, .fb_amp_code,
   .gate_demand_high, .gate_demand_low, .phase_u_high_gate, .phase_v_high_gate,
   .phase_w_high_gate, .phase_u_low_gate, .phase_v_low_gate, .phase_w_low_gate,
   .speed_pulse_output, .lock_inhibit);
`default_nettype wire

// >>> testbench/mfg_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module mfg_host_model #(
   parameter int HALF = 8
) (
   input wire logic aclk,   // Clock.
   input wire logic run,    // High keeps the reference running.
   output var logic ref_clk // Speed reference clock.
);
   // ----
   // Reference clock
   // ----
   int cnt_q = 0;
   initial ref_clk = 1'b0;
   // The period is kept well inside the loss limit; stopping holds the level.
   always @(posedge aclk) begin
      if (run && cnt_q == HALF - 1) begin
         cnt_q <= 0;
         ref_clk <= ~ref_clk;
      end else if (run) begin
         cnt_q <= cnt_q + 1;
      end
   end
endmodule
`default_nettype wire
